// [verilog/smpb_pkg.sv]
// Package: parameter indices, limits, reset values, error codes and carrier types of the motion parameter bank
package smpb_pkg;

  // Parameter indices
  localparam logic [4:0] IDX_POS       = 5'h00;
  localparam logic [4:0] IDX_ABS       = 5'h01;
  localparam logic [4:0] IDX_REL       = 5'h02;
  localparam logic [4:0] IDX_HOME      = 5'h03;
  localparam logic [4:0] IDX_STOP      = 5'h04;
  localparam logic [4:0] IDX_RUN_CUR   = 5'h05;
  localparam logic [4:0] IDX_HOLD_CUR  = 5'h06;
  localparam logic [4:0] IDX_ACCEL     = 5'h07;
  localparam logic [4:0] IDX_DECEL     = 5'h08;
  localparam logic [4:0] IDX_SPEED     = 5'h09;
  localparam logic [4:0] IDX_HSPEED    = 5'h0a;
  localparam logic [4:0] IDX_HDIR_INV  = 5'h0b;
  localparam logic [4:0] IDX_HOME_PWR  = 5'h0c;
  localparam logic [4:0] IDX_ENC_KIND  = 5'h0d;
  localparam logic [4:0] IDX_POLES     = 5'h0e;
  localparam logic [4:0] IDX_POLE_LEN  = 5'h0f;
  localparam logic [4:0] IDX_INTERP    = 5'h10;
  localparam logic [4:0] IDX_RATIO     = 5'h11;
  localparam logic [4:0] IDX_PH_SWAP   = 5'h12;
  localparam logic [4:0] IDX_GAIN_P    = 5'h13;
  localparam logic [4:0] IDX_GAIN_I    = 5'h14;
  localparam logic [4:0] IDX_HTIME     = 5'h15;
  localparam logic [4:0] IDX_SW_EN     = 5'h16;
  localparam logic [4:0] IDX_SW_POL    = 5'h17;
  localparam logic [4:0] IDX_SPAN_LIM  = 5'h18;
  localparam logic [4:0] IDX_MDIR_INV  = 5'h19;
  localparam logic [4:0] IDX_BL_MODE   = 5'h1a;
  localparam logic [4:0] IDX_BL_AMT    = 5'h1b;
  localparam logic [4:0] IDX_BL_HOME   = 5'h1c;
  localparam logic [4:0] IDX_GAIN_D    = 5'h1d;
  localparam logic [4:0] IDX_LAST      = 5'h1d;

  // Limits
  localparam logic [31:0] TRIG_MAX     = 32'h0000_0001;
  localparam logic [31:0] CUR_MAX      = 32'h0000_0546;
  localparam logic [31:0] RATE_MIN     = 32'h0000_0064;
  localparam logic [31:0] RATE_MAX     = 32'h0007_a120;
  localparam logic [31:0] SPD_MIN      = 32'h0000_03e8;
  localparam logic [31:0] SPD_MAX      = 32'h0098_9680;
  localparam logic [31:0] ENC_KIND_MAX = 32'h0000_0002;
  localparam logic [31:0] CNT_MIN      = 32'h0000_0001;
  localparam logic [31:0] CNT_MAX      = 32'h0001_86a0;
  localparam logic [31:0] PLEN_MIN     = 32'h3dcc_cccd;
  localparam logic [31:0] PLEN_MAX     = 32'h4120_0000;
  localparam logic [31:0] RATIO_MIN    = 32'h3a83_126f;
  localparam logic [31:0] FLT_MAX      = 32'h447a_0000;
  localparam logic [31:0] HTIME_MAX    = 32'h0000_0032;
  localparam logic [31:0] BL_MODE_MAX  = 32'h0000_0003;
  localparam logic signed [31:0] BL_MIN = -32'sh0000_c350;
  localparam logic signed [31:0] BL_MAX = 32'sh0000_c350;

  // Reset values of the non-zero attributes
  localparam logic [31:0] RST_RATE     = 32'h0000_0064;
  localparam logic [31:0] RST_SPEED    = 32'h0000_03e8;
  localparam logic [31:0] RST_COUNT    = 32'h0000_0001;
  localparam logic [31:0] RST_FLT_ONE  = 32'h3f80_0000;

  // Answer codes
  localparam logic [15:0] OK_CODE               = 16'h0000;
  localparam logic [15:0] UNKNOWN_INDEX_CODE    = 16'h0002;
  localparam logic [15:0] RANGE_ERROR_CODE      = 16'h0003;
  localparam logic [15:0] READ_ONLY_WRITE_ERROR = 16'h0005;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SMPB_HM_IDLE    = 2'b00,
    SMPB_HM_RUN     = 2'b01,
    SMPB_HM_TIMEOUT = 2'b11
  } smpb_home_e;

  // Settings handed to the motion core
  typedef struct packed {
    logic [31:0] run_current;
    logic [31:0] hold_current;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] speed;
    logic [31:0] homing_speed;
    logic        homing_reverse;
    logic [1:0]  encoder_kind;
    logic [31:0] pole_count;
    logic [31:0] pole_length;
    logic [31:0] interp_factor;
    logic [31:0] motor_enc_ratio;
    logic [31:0] gain_p;
    logic [31:0] gain_i;
    logic [31:0] gain_d;
    logic        span_limit;
    logic [1:0]  backlash_mode;
    logic [31:0] backlash_amount;
    logic [31:0] backlash_home;
  } smpb_cfg_s;

  function automatic logic [31:0] smpb_rst_val(input logic [4:0] idx);
    case (idx)
      IDX_ACCEL, IDX_DECEL:                smpb_rst_val = RST_RATE;
      IDX_SPEED, IDX_HSPEED:               smpb_rst_val = RST_SPEED;
      IDX_POLES, IDX_INTERP:               smpb_rst_val = RST_COUNT;
      IDX_POLE_LEN, IDX_RATIO:             smpb_rst_val = RST_FLT_ONE;
      default:                             smpb_rst_val = 32'h0000_0000;
    endcase
  endfunction

endpackage

// [verilog/smpb_bank.sv]
// Module: parameter bank of one stepper motion channel with actions, homing supervision and pin conditioning
//
// Summary of operation
// - Attribute writes act at once, reads return them
// - Action write of one triggers, then reverts
// - Action reads have no effect, return zero
// - Index 0 reads signed present position
// - Index 1 write commands absolute move
// - Index 2 write commands relative move
// - Index 3 one starts homing, range 0..1
// - Index 4 one stops the motor
// - Run and hold currents 0..1350 mA
// - Acceleration and deceleration 100..500000
// - Move and homing speed 1000..10000000
// - Index 11 reverses homing search direction
// - Index 12 accepts 0..1 but reset reloads it; homing at every reset is set by HOME_AT_START
// - Index 13 encoder kind 0..2
// - Index 18 swaps encoder A and B
// - PID gains are floats 0.0..1000.0
// - Index 21 homing timeout 0..50 s
// - Index 22 uses limit switch without encoder
// - Index 23 inverts limit switch polarity
// - Index 24 restricts targets to encoder span
// - Backlash mode 0..3; index 25 inverts direction
// - Backlash amounts signed -50000..50000
// - Out-of-range write answers code 3
// - Write to read-only answers code 5
`timescale 1ns/1ps

module smpb_bank #(
  parameter int unsigned TICK_CYCLES   = smpb_pkg::SEC_CYCLES,
  parameter logic        HOME_AT_START = 1'b0
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // Parameter access
  input  wire logic               req_valid,
  input  wire logic               req_write,
  input  wire logic [4:0]         req_index,
  input  wire logic [31:0]        req_wdata,
  output logic                    resp_valid,
  output logic [31:0]             resp_rdata,
  output logic [15:0]             resp_error,
  // Motion core status
  input  wire logic signed [31:0] pos_now,
  input  wire logic signed [31:0] enc_span_lo,
  input  wire logic signed [31:0] enc_span_hi,
  input  wire logic               home_found,
  input  wire logic               dir_request,
  // Motion core commands
  output logic                    move_abs,
  output logic                    move_rel,
  output logic [31:0]             move_value,
  output logic                    stop_cmd,
  output logic                    home_start,
  output logic                    home_busy,
  output logic                    home_timeout,
  output logic                    motor_dir,
  output smpb_pkg::smpb_cfg_s     cfg,
  // Encoder and reference switch pins
  input  wire logic               enc_a_pin,
  input  wire logic               enc_b_pin,
  input  wire logic               ref_sw_pin,
  output logic                    enc_a,
  output logic                    enc_b,
  output logic                    ref_detect
);

  typedef struct packed {
    logic [31:0][31:0]    prm;
    logic                 resp_valid;
    logic [31:0]          resp_rdata;
    logic [15:0]          resp_error;
    logic                 move_abs;
    logic                 move_rel;
    logic [31:0]          move_value;
    logic                 stop_cmd;
    logic                 home_start;
    logic                 home_timeout;
    smpb_pkg::smpb_home_e home;
    logic [5:0]           home_secs;
    logic [31:0]          tick_cnt;
    logic                 boot_pending;
    logic [2:0]           sync1;
    logic [2:0]           sync2;
    logic                 enc_a;
    logic                 enc_b;
    logic                 ref_detect;
  } smpb_state_s;

  smpb_state_s s_q;
  smpb_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Range check of a written value

  function automatic logic value_ok(input logic [4:0] idx, input logic [31:0] v);
    case (idx)
      smpb_pkg::IDX_ABS,
      smpb_pkg::IDX_REL:      value_ok = 1'b1;
      smpb_pkg::IDX_HOME,
      smpb_pkg::IDX_STOP,
      smpb_pkg::IDX_HDIR_INV,
      smpb_pkg::IDX_HOME_PWR,
      smpb_pkg::IDX_PH_SWAP,
      smpb_pkg::IDX_SW_EN,
      smpb_pkg::IDX_SW_POL,
      smpb_pkg::IDX_SPAN_LIM,
      smpb_pkg::IDX_MDIR_INV: value_ok = (v <= smpb_pkg::TRIG_MAX);
      smpb_pkg::IDX_RUN_CUR,
      smpb_pkg::IDX_HOLD_CUR: value_ok = (v <= smpb_pkg::CUR_MAX);
      smpb_pkg::IDX_ACCEL,
      smpb_pkg::IDX_DECEL:    value_ok = (v >= smpb_pkg::RATE_MIN) && (v <= smpb_pkg::RATE_MAX);
      smpb_pkg::IDX_SPEED,
      smpb_pkg::IDX_HSPEED:   value_ok = (v >= smpb_pkg::SPD_MIN) && (v <= smpb_pkg::SPD_MAX);
      smpb_pkg::IDX_ENC_KIND: value_ok = (v <= smpb_pkg::ENC_KIND_MAX);
      smpb_pkg::IDX_POLES,
      smpb_pkg::IDX_INTERP:   value_ok = (v >= smpb_pkg::CNT_MIN) && (v <= smpb_pkg::CNT_MAX);
      smpb_pkg::IDX_POLE_LEN: value_ok = (v >= smpb_pkg::PLEN_MIN) && (v <= smpb_pkg::PLEN_MAX);
      smpb_pkg::IDX_RATIO:    value_ok = (v >= smpb_pkg::RATIO_MIN) && (v <= smpb_pkg::FLT_MAX);
      // Positive floats order like unsigned words; sign bit set is refused
      smpb_pkg::IDX_GAIN_P,
      smpb_pkg::IDX_GAIN_I,
      smpb_pkg::IDX_GAIN_D:   value_ok = (v <= smpb_pkg::FLT_MAX);
      smpb_pkg::IDX_HTIME:    value_ok = (v <= smpb_pkg::HTIME_MAX);
      smpb_pkg::IDX_BL_MODE:  value_ok = (v <= smpb_pkg::BL_MODE_MAX);
      smpb_pkg::IDX_BL_AMT,
      smpb_pkg::IDX_BL_HOME:  value_ok = ($signed(v) >= smpb_pkg::BL_MIN) && ($signed(v) <= smpb_pkg::BL_MAX);
      default:                value_ok = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic        wr_ok;
  logic        target_ok;
  logic [32:0] rel_sum;
  logic [31:0] abs_target;
  logic        tick;
  logic        ref_raw;

  always_comb begin
    s_d = s_q;
    s_d.resp_valid   = 1'b0;
    s_d.move_abs     = 1'b0;
    s_d.move_rel     = 1'b0;
    s_d.stop_cmd     = 1'b0;
    s_d.home_start   = 1'b0;
    s_d.home_timeout = 1'b0;

    // Pin synchronisers and conditioning
    s_d.sync1 = {ref_sw_pin, enc_b_pin, enc_a_pin};
    s_d.sync2 = s_q.sync1;
    if (s_q.prm[smpb_pkg::IDX_PH_SWAP][0]) begin
      s_d.enc_a = s_q.sync2[1];
      s_d.enc_b = s_q.sync2[0];
    end else begin
      s_d.enc_a = s_q.sync2[0];
      s_d.enc_b = s_q.sync2[1];
    end
    ref_raw = s_q.sync2[2] ^ s_q.prm[smpb_pkg::IDX_SW_POL][0];
    s_d.ref_detect = ref_raw && s_q.prm[smpb_pkg::IDX_SW_EN][0]
                     && (s_q.prm[smpb_pkg::IDX_ENC_KIND][1:0] == 2'b00);

    // Target check against the encoder span
    rel_sum    = {pos_now[31], pos_now} + {req_wdata[31], req_wdata};
    abs_target = (req_index == smpb_pkg::IDX_REL) ? rel_sum[31:0] : req_wdata;
    target_ok  = 1'b1;
    if (s_q.prm[smpb_pkg::IDX_SPAN_LIM][0] && (s_q.prm[smpb_pkg::IDX_ENC_KIND][1:0] != 2'b00)
        && ((req_index == smpb_pkg::IDX_ABS) || (req_index == smpb_pkg::IDX_REL))) begin
      target_ok = ($signed(abs_target) >= enc_span_lo) && ($signed(abs_target) <= enc_span_hi)
                  && (rel_sum[32] == rel_sum[31]);
    end
    wr_ok = 1'b0;

    // Parameter access
    if (req_valid) begin
      s_d.resp_valid = 1'b1;
      s_d.resp_rdata = 32'h0000_0000;
      s_d.resp_error = smpb_pkg::OK_CODE;
      if (req_index > smpb_pkg::IDX_LAST) begin
        s_d.resp_error = smpb_pkg::UNKNOWN_INDEX_CODE;
      end else if (!req_write) begin
        if (req_index == smpb_pkg::IDX_POS) begin
          s_d.resp_rdata = pos_now;
        end else if (req_index <= smpb_pkg::IDX_STOP) begin
          s_d.resp_rdata = 32'h0000_0000;
        end else begin
          s_d.resp_rdata = s_q.prm[req_index];
        end
      end else if (req_index == smpb_pkg::IDX_POS) begin
        s_d.resp_error = smpb_pkg::READ_ONLY_WRITE_ERROR;
      end else if (!value_ok(req_index, req_wdata) || !target_ok) begin
        s_d.resp_error = smpb_pkg::RANGE_ERROR_CODE;
      end else begin
        wr_ok = 1'b1;
      end
    end

    if (wr_ok) begin
      case (req_index)
        smpb_pkg::IDX_ABS: begin
          s_d.move_abs   = 1'b1;
          s_d.move_value = req_wdata;
        end
        smpb_pkg::IDX_REL: begin
          s_d.move_rel   = 1'b1;
          s_d.move_value = req_wdata;
        end
        smpb_pkg::IDX_HOME: s_d.home_start = req_wdata[0];
        smpb_pkg::IDX_STOP: s_d.stop_cmd   = req_wdata[0];
        default:            s_d.prm[req_index] = req_wdata;
      endcase
    end

    // One homing run after every reset when enabled
    if (s_q.boot_pending) begin
      s_d.boot_pending = 1'b0;
      s_d.home_start   = s_d.home_start || s_q.prm[smpb_pkg::IDX_HOME_PWR][0];
    end

    // Second divider for the homing timeout
    tick = (s_q.tick_cnt == TICK_CYCLES - 1);
    s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;

    // Homing supervision
    case (s_q.home)
      smpb_pkg::SMPB_HM_IDLE: begin
        if (s_q.home_start) begin
          s_d.home      = smpb_pkg::SMPB_HM_RUN;
          s_d.home_secs = 6'h00;
          s_d.tick_cnt  = 32'h0000_0000;
        end
      end
      smpb_pkg::SMPB_HM_RUN: begin
        if (home_found || s_q.stop_cmd) begin
          s_d.home = smpb_pkg::SMPB_HM_IDLE;
        end else if (tick) begin
          s_d.home_secs = s_q.home_secs + 6'h01;
          // A limit of zero means no time bound
          if ((s_q.prm[smpb_pkg::IDX_HTIME][5:0] != 6'h00)
              && (s_q.home_secs + 6'h01 >= s_q.prm[smpb_pkg::IDX_HTIME][5:0])) begin
            s_d.home = smpb_pkg::SMPB_HM_TIMEOUT;
          end
        end
      end
      smpb_pkg::SMPB_HM_TIMEOUT: begin
        s_d.home_timeout = 1'b1;
        s_d.home         = smpb_pkg::SMPB_HM_IDLE;
      end
      default: s_d.home = smpb_pkg::SMPB_HM_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) begin
        s_q.prm[i] <= smpb_pkg::smpb_rst_val(5'(i));
      end
      s_q.prm[smpb_pkg::IDX_HOME_PWR] <= {31'h0000_0000, HOME_AT_START};
      s_q.resp_valid   <= 1'b0;
      s_q.resp_rdata   <= 32'h0000_0000;
      s_q.resp_error   <= 16'h0000;
      s_q.move_abs     <= 1'b0;
      s_q.move_rel     <= 1'b0;
      s_q.move_value   <= 32'h0000_0000;
      s_q.stop_cmd     <= 1'b0;
      s_q.home_start   <= 1'b0;
      s_q.home_timeout <= 1'b0;
      s_q.home         <= smpb_pkg::SMPB_HM_IDLE;
      s_q.home_secs    <= 6'h00;
      s_q.tick_cnt     <= 32'h0000_0000;
      s_q.boot_pending <= 1'b1;
      s_q.sync1        <= 3'h0;
      s_q.sync2        <= 3'h0;
      s_q.enc_a        <= 1'b0;
      s_q.enc_b        <= 1'b0;
      s_q.ref_detect   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign resp_valid   = s_q.resp_valid;
  assign resp_rdata   = s_q.resp_rdata;
  assign resp_error   = s_q.resp_error;
  assign move_abs     = s_q.move_abs;
  assign move_rel     = s_q.move_rel;
  assign move_value   = s_q.move_value;
  assign stop_cmd     = s_q.stop_cmd;
  assign home_start   = s_q.home_start;
  assign home_busy    = (s_q.home == smpb_pkg::SMPB_HM_RUN);
  assign home_timeout = s_q.home_timeout;
  assign motor_dir    = dir_request ^ s_q.prm[smpb_pkg::IDX_MDIR_INV][0];
  assign enc_a        = s_q.enc_a;
  assign enc_b        = s_q.enc_b;
  assign ref_detect   = s_q.ref_detect;

  assign cfg.run_current     = s_q.prm[smpb_pkg::IDX_RUN_CUR];
  assign cfg.hold_current    = s_q.prm[smpb_pkg::IDX_HOLD_CUR];
  assign cfg.accel           = s_q.prm[smpb_pkg::IDX_ACCEL];
  assign cfg.decel           = s_q.prm[smpb_pkg::IDX_DECEL];
  assign cfg.speed           = s_q.prm[smpb_pkg::IDX_SPEED];
  assign cfg.homing_speed    = s_q.prm[smpb_pkg::IDX_HSPEED];
  assign cfg.homing_reverse  = s_q.prm[smpb_pkg::IDX_HDIR_INV][0];
  assign cfg.encoder_kind    = s_q.prm[smpb_pkg::IDX_ENC_KIND][1:0];
  assign cfg.pole_count      = s_q.prm[smpb_pkg::IDX_POLES];
  assign cfg.pole_length     = s_q.prm[smpb_pkg::IDX_POLE_LEN];
  assign cfg.interp_factor   = s_q.prm[smpb_pkg::IDX_INTERP];
  assign cfg.motor_enc_ratio = s_q.prm[smpb_pkg::IDX_RATIO];
  assign cfg.gain_p          = s_q.prm[smpb_pkg::IDX_GAIN_P];
  assign cfg.gain_i          = s_q.prm[smpb_pkg::IDX_GAIN_I];
  assign cfg.gain_d          = s_q.prm[smpb_pkg::IDX_GAIN_D];
  assign cfg.span_limit      = s_q.prm[smpb_pkg::IDX_SPAN_LIM][0];
  assign cfg.backlash_mode   = s_q.prm[smpb_pkg::IDX_BL_MODE][1:0];
  assign cfg.backlash_amount = s_q.prm[smpb_pkg::IDX_BL_AMT];
  assign cfg.backlash_home   = s_q.prm[smpb_pkg::IDX_BL_HOME];

endmodule // smpb_bank

// [tb/smpb_bank_assertions.sv]
// Checker: access protocol, action and homing properties of the motion parameter bank
`timescale 1ns/1ps

module smpb_bank_checker #(
  parameter int unsigned TICK_CYCLES   = 10,
  parameter logic        HOME_AT_START = 1'b0
) (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rstn,
  // Parameter access
  input wire logic                req_valid,
  input wire logic                req_write,
  input wire logic [4:0]          req_index,
  input wire logic [31:0]         req_wdata,
  input wire logic                resp_valid,
  input wire logic [31:0]         resp_rdata,
  input wire logic [15:0]         resp_error,
  // Motion core commands
  input wire logic                move_abs,
  input wire logic [31:0]         move_value,
  input wire logic                stop_cmd,
  input wire logic                home_start,
  input wire logic                home_busy,
  input wire logic                home_timeout,
  input wire smpb_pkg::smpb_cfg_s cfg
);
  logic wr;

  assign wr = req_valid && req_write;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  resp_latency_a: assert property (req_valid |=> resp_valid)
    else $error("answer missing");
  no_spurious_a: assert property (!req_valid |=> !resp_valid)
    else $error("answer without request");
  home_trigger_a: assert property (wr && req_index == 5'h03 && req_wdata == 32'h1 |=> home_start && resp_error == 16'h0)
    else $error("homing not started");
  stop_trigger_a: assert property (wr && req_index == 5'h04 && req_wdata == 32'h1 |=> stop_cmd)
    else $error("stop not issued");
  abs_move_a: assert property (wr && req_index == 5'h01 && !cfg.span_limit |=> move_abs && move_value == $past(req_wdata))
    else $error("absolute move wrong");
  read_only_a: assert property (wr && req_index == 5'h00 |=> resp_error == 16'h5 && !move_abs)
    else $error("read-only write accepted");
  range_refuse_a: assert property (wr && req_index == 5'h05 && req_wdata > 32'h546 |=> resp_error == 16'h3 && $stable(cfg.run_current))
    else $error("current range not refused");
  accel_apply_a: assert property (wr && req_index == 5'h07 && req_wdata inside {[32'h64:32'h7a120]} |=> cfg.accel == $past(req_wdata))
    else $error("acceleration not applied");
  action_read_a: assert property (req_valid && !req_write && req_index inside {[5'h01:5'h04]} |=> resp_rdata == 32'h0 && !stop_cmd && !move_abs)
    else $error("action read had effect");
  busy_follow_a: assert property (home_start && !home_busy |=> home_busy)
    else $error("homing not busy");
  timeout_order_a: assert property (home_timeout |-> !$past(home_busy) && $past(home_busy, 2))
    else $error("timeout out of order");

  cover property (home_timeout);
  cover property (wr && req_index == 5'h05 ##1 resp_error == 16'h3);
  cover property (move_abs);
endmodule // smpb_bank_checker

bind smpb_bank smpb_bank_checker #(.TICK_CYCLES(TICK_CYCLES), .HOME_AT_START(HOME_AT_START)) i_smpb_bank_checker (
  .clk_sys, .rstn, .req_valid, .req_write, .req_index, .req_wdata, .resp_valid, .resp_rdata, .resp_error,
  .move_abs, .move_value, .stop_cmd, .home_start, .home_busy, .home_timeout, .cfg
);

// [tb/smpb_core_model.sv]
// Partner: behavioural motion core that follows move and homing commands
`timescale 1ns/1ps

module smpb_core_model #(
  parameter int unsigned FIND_DELAY = 5
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // Commands from the bank
  input  wire logic               move_abs,
  input  wire logic               move_rel,
  input  wire logic [31:0]        move_value,
  input  wire logic               home_start,
  // Scenario control
  input  wire logic               find_en,
  // Status to the bank
  output logic signed [31:0]      pos_now,
  output logic                    home_found
);
  int unsigned cnt;

  // Jumps straight to the target; ramps are not modelled
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pos_now    <= '0;
      cnt        <= 0;
      home_found <= 1'b0;
    end else begin
      home_found <= 1'b0;
      if (move_abs) pos_now <= move_value;
      else if (move_rel) pos_now <= $signed(pos_now + move_value);
      if (home_start) cnt <= FIND_DELAY;
      else if (cnt != 0) begin
        cnt <= cnt - 1;
        if (cnt == 1 && find_en) begin
          home_found <= 1'b1;
          pos_now    <= '0;
        end
      end
    end
  end
endmodule // smpb_core_model

// [tb/tb_smpb_bank.sv]
// Testbench: parameter access, actions, homing and pin conditioning of the motion parameter bank
`timescale 1ns/1ps

`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected at %0t: %s", $time, m); end end

module tb_smpb_bank;
  localparam logic [15:0] OK  = smpb_pkg::OK_CODE;
  localparam logic [15:0] RNG = smpb_pkg::RANGE_ERROR_CODE;
  localparam logic [31:0] BLN = smpb_pkg::BL_MIN;
  localparam logic [31:0] BLX = smpb_pkg::BL_MAX;

  logic                clk_sys = 1'b0;
  logic                rstn = 1'b0;
  logic                req_valid = 1'b0;
  logic                req_write = 1'b0;
  logic [4:0]          req_index = '0;
  logic [31:0]         req_wdata = '0;
  logic                resp_valid, move_abs, move_rel, stop_cmd, home_start, home_busy, home_timeout;
  logic [31:0]         resp_rdata, move_value;
  logic [15:0]         resp_error;
  logic signed [31:0]  pos_now;
  logic                home_found, motor_dir, enc_a, enc_b, ref_detect;
  logic                dir_request = 1'b1;
  logic                enc_a_pin = 1'b1;
  logic                enc_b_pin = 1'b0;
  logic                ref_sw_pin = 1'b1;
  logic                find_en = 1'b1;
  smpb_pkg::smpb_cfg_s cfg;
  int                  n_mismatch = 0;
  int                  check_count = 0;
  int                  n;
  logic [4:0]          t_idx [13] = '{5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0d, 5'h13, 5'h15, 5'h16, 5'h1a, 5'h1b, 5'h1c};
  logic [31:0]         t_lo [13] = '{'0, '0, smpb_pkg::RATE_MIN, smpb_pkg::SPD_MIN, smpb_pkg::SPD_MIN, '0, '0, '0, '0, '0, '0,
                                     BLN, BLN};
  logic [31:0]         t_hi [13] = '{smpb_pkg::CUR_MAX, smpb_pkg::CUR_MAX, smpb_pkg::RATE_MAX, smpb_pkg::SPD_MAX,
                                     smpb_pkg::SPD_MAX, smpb_pkg::TRIG_MAX, smpb_pkg::ENC_KIND_MAX, smpb_pkg::FLT_MAX,
                                     smpb_pkg::HTIME_MAX, smpb_pkg::TRIG_MAX, smpb_pkg::BL_MODE_MAX, BLX, BLX};

  always #2 clk_sys = ~clk_sys;

  smpb_bank #(.TICK_CYCLES(10), .HOME_AT_START(1'b1)) i_smpb_bank (
    .clk_sys, .rstn, .req_valid, .req_write, .req_index, .req_wdata, .resp_valid, .resp_rdata, .resp_error,
    .pos_now, .enc_span_lo(32'hffff_ff9c), .enc_span_hi(32'h0000_0064), .home_found, .dir_request,
    .move_abs, .move_rel, .move_value, .stop_cmd, .home_start, .home_busy, .home_timeout, .motor_dir, .cfg,
    .enc_a_pin, .enc_b_pin, .ref_sw_pin, .enc_a, .enc_b, .ref_detect
  );

  smpb_core_model i_smpb_core_model (
    .clk_sys, .rstn, .move_abs, .move_rel, .move_value, .home_start, .find_en, .pos_now, .home_found
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic acc(input logic w, input logic [4:0] i, input logic [31:0] d);
    cyc(1);
    {req_valid, req_write, req_index, req_wdata} = {1'b1, w, i, d};
    cyc(1);
    req_valid = 1'b0;
    `CHK(resp_valid, 1'b1, "no answer")
  endtask

  task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic [15:0] e);
    acc(1'b1, i, d);
    `CHK(resp_error, e, "write answer")
  endtask

  task automatic rd(input logic [4:0] i, input logic [31:0] d);
    acc(1'b0, i, '0);
    `CHK(resp_rdata, d, "read value")
  endtask

  task automatic print_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    rstn = 1'b1;
    for (n = 0; n < 4 && home_start !== 1'b1; n++) cyc(1);
    `CHK(home_start, 1'b1, "no start-up homing")
    cyc(1);
    `CHK(home_busy, 1'b1, "homing not running")
    for (n = 0; n < 12 && home_busy !== 1'b0; n++) cyc(1);
    `CHK(home_busy, 1'b0, "homing not ended")
    rd(5'h07, smpb_pkg::RST_RATE);
    rd(5'h09, smpb_pkg::RST_SPEED);
    rd(5'h0f, smpb_pkg::RST_FLT_ONE);
    for (int k = 0; k < 13; k++) begin
      wr(t_idx[k], t_lo[k], OK);
      wr(t_idx[k], t_lo[k] - 32'h1, RNG);
      wr(t_idx[k], t_hi[k] + 32'h1, RNG);
      rd(t_idx[k], t_lo[k]);
      wr(t_idx[k], t_hi[k], OK);
      rd(t_idx[k], t_hi[k]);
    end
    `CHK(cfg.run_current, smpb_pkg::CUR_MAX, "run current")
    `CHK(cfg.homing_reverse, 1'b1, "homing reverse")
    `CHK(cfg.gain_p, smpb_pkg::FLT_MAX, "gain")
    `CHK(cfg.backlash_home, BLX, "backlash on homing")
    for (int m = 0; m < 4; m++) begin
      wr(5'h1a, 32'(m), OK);
      `CHK(cfg.backlash_mode, 2'(m), "backlash mode")
      wr(5'h0d, 32'(m % 3), OK);
      `CHK(cfg.encoder_kind, 2'(m % 3), "encoder kind")
    end
    wr(5'h00, 32'h0000_0005, smpb_pkg::READ_ONLY_WRITE_ERROR);
    wr(5'h1e, '0, smpb_pkg::UNKNOWN_INDEX_CODE);
    wr(5'h01, 32'h0000_04d2, OK);
    `CHK(move_abs, 1'b1, "absolute move")
    `CHK(move_value, 32'h0000_04d2, "target")
    rd(5'h00, 32'h0000_04d2);
    wr(5'h02, 32'hffff_ffde, OK);
    `CHK(move_rel, 1'b1, "relative move")
    rd(5'h00, 32'h0000_04b0);
    rd(5'h01, '0);
    `CHK(move_abs, 1'b0, "read side effect")
    wr(5'h04, 32'h0000_0001, OK);
    `CHK(stop_cmd, 1'b1, "stop")
    cyc(1);
    `CHK(stop_cmd, 1'b0, "stop held")
    rd(5'h04, '0);
    wr(5'h04, 32'h0000_0002, RNG);
    `CHK(stop_cmd, 1'b0, "refused stop")
    wr(5'h03, '0, OK);
    `CHK(home_start, 1'b0, "zero homing")
    wr(5'h0d, 32'h0000_0001, OK);
    wr(5'h18, 32'h0000_0001, OK);
    wr(5'h01, 32'h0000_00c8, RNG);
    `CHK(move_abs, 1'b0, "refused move")
    wr(5'h01, 32'h0000_0032, OK);
    `CHK(move_abs, 1'b1, "in-span move")
    wr(5'h0d, '0, OK);
    cyc(1);
    `CHK(enc_a, 1'b1, "encoder a")
    `CHK(ref_detect, 1'b1, "reference")
    wr(5'h12, 32'h0000_0001, OK);
    wr(5'h17, 32'h0000_0001, OK);
    cyc(4);
    `CHK({enc_a, enc_b}, 2'b01, "swapped phases")
    `CHK(ref_detect, 1'b0, "inverted reference")
    `CHK(motor_dir, 1'b1, "direction")
    wr(5'h19, 32'h0000_0001, OK);
    `CHK(motor_dir, 1'b0, "inverted direction")
    find_en = 1'b0;
    wr(5'h15, 32'h0000_0002, OK);
    wr(5'h03, 32'h0000_0001, OK);
    `CHK(home_start, 1'b1, "homing start")
    for (n = 0; n < 40 && home_timeout !== 1'b1; n++) cyc(1);
    `CHK(n > 15 && n < 27, 1'b1, "timeout span")
    `CHK(home_busy, 1'b0, "busy after timeout")
    print_verdict();
  end

  initial begin
    #40000;
    n_mismatch++;
    print_verdict();
  end
endmodule // tb_smpb_bank
